// [rtl/settings_pkg.sv]
// constants shared by the settings read responder
package settings_pkg;
  // command codes, little-endian on the link
  localparam logic [31:0] CMD_ENC_SETTINGS = 32'h736e6567;
  localparam logic [31:0] CMD_MOTOR_KIND   = 32'h746e6567;
  localparam logic [31:0] CMD_FEEDBACK     = 32'h73626667;
  // answer lengths in bytes
  localparam logic [5:0] LEN_ENC_SETTINGS = 6'h36;
  localparam logic [5:0] LEN_MOTOR_KIND   = 6'h0e;
  localparam logic [5:0] LEN_FEEDBACK     = 6'h12;
  localparam logic [5:0] CRC_BYTES        = 6'h02;
  localparam logic [1:0] REQ_LAST_BYTE    = 2'h3;
  // answer selector codes
  localparam logic [1:0] SEL_ENC  = 2'h0;
  localparam logic [1:0] SEL_MOT  = 2'h1;
  localparam logic [1:0] SEL_FBK  = 2'h2;
  // register byte addresses
  localparam logic [7:0] ADDR_MAX_FREQ    = 8'h00;
  localparam logic [7:0] ADDR_SUPPLY_MIN  = 8'h04;
  localparam logic [7:0] ADDR_SUPPLY_MAX  = 8'h08;
  localparam logic [7:0] ADDR_MAX_CURRENT = 8'h0c;
  localparam logic [7:0] ADDR_ENC_COUNTS  = 8'h10;
  localparam logic [7:0] ADDR_ENC_FLAGS   = 8'h14;
  localparam logic [7:0] ADDR_KINDS       = 8'h18;
  localparam logic [7:0] ADDR_FEEDBACK    = 8'h1c;
  localparam logic [7:0] ADDR_EXT_COUNTS  = 8'h20;
  localparam logic [7:0] ADDR_EFF_COUNTS  = 8'h24;
  localparam logic [7:0] ADDR_STATUS      = 8'h28;
  // encoder flag word bits
  localparam logic [31:0] ENC_DIFF_OUT_FLAG     = 32'h00000001;
  localparam logic [31:0] ENC_PUSH_PULL_FLAG    = 32'h00000004;
  localparam logic [31:0] ENC_INDEX_PRESENT     = 32'h00000010;
  localparam logic [31:0] ENC_REV_SENSOR_PRES   = 32'h00000040;
  localparam logic [31:0] ENC_REV_SENSOR_HIGH   = 32'h00000100;
  localparam logic [31:0] ENC_FLAG_MASK = ENC_DIFF_OUT_FLAG
    | ENC_PUSH_PULL_FLAG | ENC_INDEX_PRESENT | ENC_REV_SENSOR_PRES
    | ENC_REV_SENSOR_HIGH;
  // motor kind codes
  localparam logic [7:0] MOTOR_NONE      = 8'h00;
  localparam logic [7:0] MOTOR_DC        = 8'h01;
  localparam logic [7:0] MOTOR_DUAL_DC   = 8'h02;
  localparam logic [7:0] MOTOR_STEPPER   = 8'h03;
  localparam logic [7:0] MOTOR_TEST      = 8'h04;
  localparam logic [7:0] MOTOR_BRUSHLESS = 8'h05;
  // power stage kind codes
  localparam logic [7:0] POWER_STAGE_DISCRETE   = 8'h01;
  localparam logic [7:0] POWER_STAGE_INTEGRATED = 8'h02;
  localparam logic [7:0] POWER_STAGE_EXTERNAL   = 8'h03;
  // feedback kind codes and flag fields
  localparam logic [7:0] FEEDBACK_ENCODER   = 8'h01;
  localparam logic [7:0] FEEDBACK_BACK_EMF  = 8'h04;
  localparam logic [7:0] FEEDBACK_NONE      = 8'h05;
  localparam logic [7:0] COUNT_DIR_INVERT   = 8'h01;
  localparam logic [7:0] ENC_KIND_FIELD     = 8'hc0;
  localparam logic [7:0] ENC_KIND_AUTO      = 8'h00;
  localparam logic [7:0] ENC_KIND_SINGLE    = 8'h40;
  localparam logic [7:0] ENC_KIND_DIFF      = 8'h80;
  localparam int         ENC_KIND_LSB       = 6;
  localparam logic [15:0] LEGACY_UNUSED     = 16'h0000;
  // register reset values
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [31:0] RST_KINDS = {16'h0000, POWER_STAGE_DISCRETE,
                                       MOTOR_DC};
  localparam logic [31:0] RST_FEEDBACK = {8'h00, FEEDBACK_NONE,
                                          LEGACY_UNUSED};
  // checksum: reflected polynomial, preset
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'hffff;
endpackage : settings_pkg

// [rtl/crc_if.sv]
// checksum link between the frame engine and the checksum unit
`timescale 1ns/100ps
interface crc_if;
  logic        clr;
  logic        upd;
  logic [7:0]  din;
  logic [15:0] crc_q;
  logic [15:0] crc_nxt;
  modport engine (output clr, output upd, output din,
                  input crc_q, input crc_nxt);
  modport unit   (input clr, input upd, input din,
                  output crc_q, output crc_nxt);
endinterface : crc_if

// [rtl/answer_checksum.sv]
// running 16-bit checksum over answer bytes
`timescale 1ns/100ps
module answer_checksum (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  crc_if.unit       ck
);
  logic [15:0] crc_d;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ settings_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  always_comb
  begin
    ck.crc_nxt = crc_step(ck.crc_q, ck.din);
    crc_d = ck.crc_q;
    if (ck.clr)
    begin
      crc_d = settings_pkg::CRC_INIT;
    end
    else if (ck.upd)
    begin
      crc_d = ck.crc_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ck.crc_q <= settings_pkg::CRC_INIT;
    end
    else
    begin
      ck.crc_q <= crc_d;
    end
  end
endmodule : answer_checksum

// [rtl/settings_read_responder.sv]
// settings read responder: request decode, answer frames, settings store
// Functional notes
// - encoder settings request answered with 54 bytes echoing command
// - encoder answer: command, four floats, counts, flags, 24 zero, sum
// - encoder flag bits 0x1, 0x4, 0x10, 0x40, 0x100 keep meanings
// - motor kind request answered with 14 bytes echoing command
// - motor kind byte codes 0x0 to 0x5 as defined
// - power stage byte codes 0x1 default, 0x2, 0x3
// - feedback request answered with 18 bytes echoing command
// - flag bit 0x1 inverts count; field 0xc0 picks encoder kind
// - extended count used only when legacy count is zero
`timescale 1ns/100ps
module settings_read_responder (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic [7:0]       tx_data_q,
  output logic             tx_valid_q,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata_q,
  output logic [31:0]      counts_per_rev_q,
  output logic             count_direction_invert,
  output logic [1:0]       encoder_kind_field
);
  typedef enum logic [1:0] {
    ST_RECV = 2'b01,
    ST_SEND = 2'b10
  } state_t;

  crc_if ck ();

  answer_checksum u_sum (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .ck      (ck)
  );

  // settings store
  logic [31:0] max_freq_q, max_freq_d;
  logic [31:0] supply_min_q, supply_min_d;
  logic [31:0] supply_max_q, supply_max_d;
  logic [31:0] max_current_q, max_current_d;
  logic [31:0] counts_per_revolution_q, counts_per_revolution_d;
  logic [31:0] encoder_flag_word_q, encoder_flag_word_d;
  logic [7:0]  motor_kind_byte_q, motor_kind_byte_d;
  logic [7:0]  power_stage_kind_byte_q, power_stage_kind_byte_d;
  logic [15:0] legacy_count_field_q, legacy_count_field_d;
  logic [7:0]  feedback_kind_byte_q, feedback_kind_byte_d;
  logic [7:0]  feedback_flag_byte_q, feedback_flag_byte_d;
  logic [31:0] extended_count_field_q, extended_count_field_d;
  logic [31:0] counts_per_rev_d;
  logic [31:0] reg_rdata_d;
  // frame engine
  state_t      state_q, state_d;
  logic [1:0]  rx_cnt_q, rx_cnt_d;
  logic [31:0] cmd_q, cmd_d;
  logic [1:0]  sel_q, sel_d;
  logic [5:0]  idx_q, idx_d;
  logic [7:0]  tx_data_d;
  logic        tx_valid_d;
  logic [7:0]  unknown_cnt_q, unknown_cnt_d;
  logic [7:0]  sent_cnt_q, sent_cnt_d;
  logic [31:0] cmd_full;
  logic [5:0]  len;
  logic [5:0]  idx_nx;
  logic        rx_take;
  logic        tx_take;

  function automatic logic [5:0] frame_len(input logic [1:0] sel);
    unique case (sel)
      settings_pkg::SEL_ENC: frame_len = settings_pkg::LEN_ENC_SETTINGS;
      settings_pkg::SEL_MOT: frame_len = settings_pkg::LEN_MOTOR_KIND;
      default:               frame_len = settings_pkg::LEN_FEEDBACK;
    endcase
  endfunction : frame_len

  // word of an answer; the checksum bytes are patched in by the engine
  function automatic logic [31:0] frame_word(input logic [1:0] sel,
                                             input logic [3:0] w);
    frame_word = settings_pkg::RST_WORD;
    if (w == 4'h0)
    begin
      frame_word = cmd_q;
    end
    else if (sel == settings_pkg::SEL_ENC)
    begin
      unique case (w)
        4'h1: frame_word = max_freq_q;
        4'h2: frame_word = supply_min_q;
        4'h3: frame_word = supply_max_q;
        4'h4: frame_word = max_current_q;
        4'h5: frame_word = counts_per_revolution_q;
        4'h6: frame_word = encoder_flag_word_q;
        default: frame_word = settings_pkg::RST_WORD;
      endcase
    end
    else if (sel == settings_pkg::SEL_MOT)
    begin
      if (w == 4'h1)
      begin
        frame_word = {16'h0000, power_stage_kind_byte_q,
                      motor_kind_byte_q};
      end
    end
    else
    begin
      unique case (w)
        4'h1: frame_word = {feedback_flag_byte_q, feedback_kind_byte_q,
                            legacy_count_field_q};
        4'h2: frame_word = extended_count_field_q;
        default: frame_word = settings_pkg::RST_WORD;
      endcase
    end
  endfunction : frame_word

  function automatic logic [7:0] frame_byte(input logic [1:0] sel,
                                            input logic [5:0] i);
    logic [31:0] w;
    w = frame_word(sel, i[5:2]);
    frame_byte = w[{i[1:0], 3'b000} +: 8];
  endfunction : frame_byte

  assign rx_ready = (state_q == ST_RECV);
  assign rx_take  = rx_valid && rx_ready;
  assign tx_take  = tx_valid_q && tx_ready;
  assign cmd_full = {rx_data, cmd_q[31:8]};
  assign len      = frame_len(sel_q);
  assign idx_nx   = idx_q + 6'h01;

  assign count_direction_invert =
    |(feedback_flag_byte_q & settings_pkg::COUNT_DIR_INVERT);
  assign encoder_kind_field =
    feedback_flag_byte_q[settings_pkg::ENC_KIND_LSB +: 2];

  // checksum runs over every byte ahead of it
  assign ck.clr = rx_take && (rx_cnt_q == settings_pkg::REQ_LAST_BYTE);
  assign ck.upd = tx_take && (idx_q < (len - settings_pkg::CRC_BYTES));
  assign ck.din = tx_data_q;

  always_comb
  begin
    state_d    = state_q;
    rx_cnt_d   = rx_cnt_q;
    cmd_d      = cmd_q;
    sel_d      = sel_q;
    idx_d      = idx_q;
    tx_data_d  = tx_data_q;
    tx_valid_d = tx_valid_q;
    unknown_cnt_d = unknown_cnt_q;
    sent_cnt_d    = sent_cnt_q;
    unique case (state_q)
      ST_RECV:
      begin
        if (rx_take)
        begin
          cmd_d    = cmd_full;
          rx_cnt_d = rx_cnt_q + 2'h1;
          if (rx_cnt_q == settings_pkg::REQ_LAST_BYTE)
          begin
            state_d    = ST_SEND;
            idx_d      = 6'h00;
            tx_data_d  = cmd_full[7:0];
            tx_valid_d = 1'b1;
            if (cmd_full == settings_pkg::CMD_ENC_SETTINGS)
            begin
              sel_d = settings_pkg::SEL_ENC;
            end
            else if (cmd_full == settings_pkg::CMD_MOTOR_KIND)
            begin
              sel_d = settings_pkg::SEL_MOT;
            end
            else if (cmd_full == settings_pkg::CMD_FEEDBACK)
            begin
              sel_d = settings_pkg::SEL_FBK;
            end
            else
            begin
              state_d       = ST_RECV;
              tx_valid_d    = 1'b0;
              unknown_cnt_d = unknown_cnt_q + 8'h01;
            end
          end
        end
      end
      ST_SEND:
      begin
        if (tx_take)
        begin
          if (idx_q == len - 6'h01)
          begin
            state_d    = ST_RECV;
            tx_valid_d = 1'b0;
            sent_cnt_d = sent_cnt_q + 8'h01;
          end
          else
          begin
            idx_d = idx_nx;
            if (idx_nx == len - settings_pkg::CRC_BYTES)
            begin
              tx_data_d = ck.crc_nxt[7:0];
            end
            else if (idx_nx == len - 6'h01)
            begin
              tx_data_d = ck.crc_q[15:8];
            end
            else
            begin
              tx_data_d = frame_byte(sel_q, idx_nx);
            end
          end
        end
      end
    endcase
  end

  always_comb
  begin
    max_freq_d              = max_freq_q;
    supply_min_d            = supply_min_q;
    supply_max_d            = supply_max_q;
    max_current_d           = max_current_q;
    counts_per_revolution_d = counts_per_revolution_q;
    encoder_flag_word_d     = encoder_flag_word_q;
    motor_kind_byte_d       = motor_kind_byte_q;
    power_stage_kind_byte_d = power_stage_kind_byte_q;
    legacy_count_field_d    = legacy_count_field_q;
    feedback_kind_byte_d    = feedback_kind_byte_q;
    feedback_flag_byte_d    = feedback_flag_byte_q;
    extended_count_field_d  = extended_count_field_q;
    reg_rdata_d             = settings_pkg::RST_WORD;
    if (reg_wr)
    begin
      unique case (reg_addr)
        settings_pkg::ADDR_MAX_FREQ:    max_freq_d = reg_wdata;
        settings_pkg::ADDR_SUPPLY_MIN:  supply_min_d = reg_wdata;
        settings_pkg::ADDR_SUPPLY_MAX:  supply_max_d = reg_wdata;
        settings_pkg::ADDR_MAX_CURRENT: max_current_d = reg_wdata;
        settings_pkg::ADDR_ENC_COUNTS:  counts_per_revolution_d = reg_wdata;
        settings_pkg::ADDR_ENC_FLAGS:
          encoder_flag_word_d = reg_wdata & settings_pkg::ENC_FLAG_MASK;
        settings_pkg::ADDR_KINDS:
        begin
          motor_kind_byte_d       = reg_wdata[7:0];
          power_stage_kind_byte_d = reg_wdata[15:8];
        end
        settings_pkg::ADDR_FEEDBACK:
        begin
          legacy_count_field_d = reg_wdata[15:0];
          feedback_kind_byte_d = reg_wdata[23:16];
          feedback_flag_byte_d = reg_wdata[31:24];
        end
        settings_pkg::ADDR_EXT_COUNTS: extended_count_field_d = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        settings_pkg::ADDR_MAX_FREQ:    reg_rdata_d = max_freq_q;
        settings_pkg::ADDR_SUPPLY_MIN:  reg_rdata_d = supply_min_q;
        settings_pkg::ADDR_SUPPLY_MAX:  reg_rdata_d = supply_max_q;
        settings_pkg::ADDR_MAX_CURRENT: reg_rdata_d = max_current_q;
        settings_pkg::ADDR_ENC_COUNTS:  reg_rdata_d = counts_per_revolution_q;
        settings_pkg::ADDR_ENC_FLAGS:   reg_rdata_d = encoder_flag_word_q;
        settings_pkg::ADDR_KINDS:
          reg_rdata_d = {16'h0000, power_stage_kind_byte_q,
                         motor_kind_byte_q};
        settings_pkg::ADDR_FEEDBACK:
          reg_rdata_d = {feedback_flag_byte_q, feedback_kind_byte_q,
                         legacy_count_field_q};
        settings_pkg::ADDR_EXT_COUNTS:  reg_rdata_d = extended_count_field_q;
        settings_pkg::ADDR_EFF_COUNTS:  reg_rdata_d = counts_per_rev_q;
        settings_pkg::ADDR_STATUS:
          reg_rdata_d = {8'h00, sent_cnt_q, unknown_cnt_q, 7'h00,
                         (state_q == ST_SEND)};
        default: reg_rdata_d = settings_pkg::RST_WORD;
      endcase
    end
    // legacy count wins unless zero
    counts_per_rev_d = (legacy_count_field_q == settings_pkg::LEGACY_UNUSED)
                     ? extended_count_field_q
                     : {16'h0000, legacy_count_field_q};
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      max_freq_q              <= settings_pkg::RST_WORD;
      supply_min_q            <= settings_pkg::RST_WORD;
      supply_max_q            <= settings_pkg::RST_WORD;
      max_current_q           <= settings_pkg::RST_WORD;
      counts_per_revolution_q <= settings_pkg::RST_WORD;
      encoder_flag_word_q     <= settings_pkg::RST_WORD;
      motor_kind_byte_q       <= settings_pkg::RST_KINDS[7:0];
      power_stage_kind_byte_q <= settings_pkg::RST_KINDS[15:8];
      legacy_count_field_q    <= settings_pkg::RST_FEEDBACK[15:0];
      feedback_kind_byte_q    <= settings_pkg::RST_FEEDBACK[23:16];
      feedback_flag_byte_q    <= settings_pkg::RST_FEEDBACK[31:24];
      extended_count_field_q  <= settings_pkg::RST_WORD;
      counts_per_rev_q        <= settings_pkg::RST_WORD;
      reg_rdata_q             <= settings_pkg::RST_WORD;
    end
    else
    begin
      max_freq_q              <= max_freq_d;
      supply_min_q            <= supply_min_d;
      supply_max_q            <= supply_max_d;
      max_current_q           <= max_current_d;
      counts_per_revolution_q <= counts_per_revolution_d;
      encoder_flag_word_q     <= encoder_flag_word_d;
      motor_kind_byte_q       <= motor_kind_byte_d;
      power_stage_kind_byte_q <= power_stage_kind_byte_d;
      legacy_count_field_q    <= legacy_count_field_d;
      feedback_kind_byte_q    <= feedback_kind_byte_d;
      feedback_flag_byte_q    <= feedback_flag_byte_d;
      extended_count_field_q  <= extended_count_field_d;
      counts_per_rev_q        <= counts_per_rev_d;
      reg_rdata_q             <= reg_rdata_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q       <= ST_RECV;
      rx_cnt_q      <= 2'h0;
      cmd_q         <= settings_pkg::RST_WORD;
      sel_q         <= settings_pkg::SEL_ENC;
      idx_q         <= 6'h00;
      tx_data_q     <= 8'h00;
      tx_valid_q    <= 1'b0;
      unknown_cnt_q <= 8'h00;
      sent_cnt_q    <= 8'h00;
    end
    else
    begin
      state_q       <= state_d;
      rx_cnt_q      <= rx_cnt_d;
      cmd_q         <= cmd_d;
      sel_q         <= sel_d;
      idx_q         <= idx_d;
      tx_data_q     <= tx_data_d;
      tx_valid_q    <= tx_valid_d;
      unknown_cnt_q <= unknown_cnt_d;
      sent_cnt_q    <= sent_cnt_d;
    end
  end
endmodule : settings_read_responder

// [verif/responder_chk.sv]
// assertion checker for the settings read responder ports
`timescale 1ns/100ps
module responder_chk (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic [7:0]  tx_data_q,
  input wire logic        tx_valid_q,
  input wire logic        tx_ready,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_q,
  input wire logic [31:0] counts_per_rev_q,
  input wire logic        count_direction_invert,
  input wire logic [1:0]  encoder_kind_field
);
  localparam logic [31:0] UNKNOWN_CMD = 32'h12345678;
  wire take  = rx_valid & rx_ready;
  wire fb_wr = reg_wr & (reg_addr == settings_pkg::ADDR_FEEDBACK);
  wire ef_wr = reg_wr & (reg_addr == settings_pkg::ADDR_ENC_FLAGS);
  wire ef_rd = reg_rd & (reg_addr == settings_pkg::ADDR_ENC_FLAGS);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // four request bytes, low byte first
  sequence s_req(logic [31:0] c);
    take && rx_data == c[7:0] ##1 take && rx_data == c[15:8]
    ##1 take && rx_data == c[23:16] ##1 take && rx_data == c[31:24];
  endsequence
  property p_echo(logic [31:0] c);
    s_req(c) |=> (tx_valid_q && tx_data_q == c[7:0]);
  endproperty
  a_echo_enc:
    assert property (p_echo(settings_pkg::CMD_ENC_SETTINGS))
    else $error("encoder answer lacks echo");
  a_echo_motor:
    assert property (p_echo(settings_pkg::CMD_MOTOR_KIND))
    else $error("motor answer lacks echo");
  a_echo_feedback:
    assert property (p_echo(settings_pkg::CMD_FEEDBACK))
    else $error("feedback answer lacks echo");
  a_no_answer: assert property (
    s_req(UNKNOWN_CMD) |=> (!tx_valid_q && rx_ready) [*8])
    else $error("unknown command answered");
  a_busy_refuse: assert property (
    tx_valid_q |-> !rx_ready)
    else $error("request taken while answering");
  a_tx_hold: assert property (
    tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q))
    else $error("answer byte dropped or changed");
  a_flag_bits: assert property (
    fb_wr |=> count_direction_invert == $past(reg_wdata[24])
      && encoder_kind_field == $past(reg_wdata[31:30]))
    else $error("feedback flag outputs wrong");
  a_legacy_wins: assert property (
    fb_wr && reg_wdata[15:0] != 16'h0 ##1 !fb_wr
      |-> ##2 counts_per_rev_q == {16'h0, $past(reg_wdata[15:0], 3)})
    else $error("legacy count not used");
  a_flag_mask: assert property (
    ef_wr ##1 ef_rd |=> reg_rdata_q
      == ($past(reg_wdata, 2) & settings_pkg::ENC_FLAG_MASK))
    else $error("encoder flag word not masked");
endmodule : responder_chk
bind settings_read_responder responder_chk chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .rx_data(rx_data),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data_q(tx_data_q),
  .tx_valid_q(tx_valid_q), .tx_ready(tx_ready), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .counts_per_rev_q(counts_per_rev_q),
  .count_direction_invert(count_direction_invert),
  .encoder_kind_field(encoder_kind_field));

// [verif/host_model.sv]
// host model: sends request words, collects answer bytes
`timescale 1ns/100ps
module host_model (
  input  wire logic       sys_clk,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data_q,
  input  wire logic       tx_valid_q,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            tx_ready
);
  logic [7:0] got[$];
  int         seed = 79889;
  bit         slow = 1'b0;
  initial
  begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  function automatic int rnd();
    return $random(seed);
  endfunction : rnd
  // takes answer bytes, stalls at random when slow
  always @(posedge sys_clk)
  begin
    if (tx_valid_q && tx_ready)
      got.push_back(tx_data_q);
    tx_ready <= !slow || ((rnd() & 1) == 1);
  end
  // four bytes low first, line shows inverse when released
  task automatic send(input logic [31:0] cmd);
    int n;
    n = 0;
    for (int i = 0; i < 4; i++)
    begin
      rx_data  <= cmd[8*i +: 8];
      rx_valid <= 1'b1;
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (!rx_ready && n < 64);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~cmd[31:24];
  endtask : send
endmodule : host_model

// [verif/tb.sv]
// self-checking bench for the settings read responder
`timescale 1ns/100ps
module tb;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_ready;
  logic [7:0]  tx_data_q;
  logic        tx_valid_q;
  logic        tx_ready;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata_q;
  logic [31:0] counts_per_rev_q;
  logic        count_direction_invert;
  logic [1:0]  encoder_kind_field;
  logic [31:0] r[11];
  logic [7:0]  exp_q[$];
  int          miscompares = 0;
  int          num_checks = 0;
  localparam logic [23:0] FB_KIND = 24'h050401;
  localparam logic [23:0] FB_FLAG = 24'h008041;
  settings_read_responder uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data_q(tx_data_q),
    .tx_valid_q(tx_valid_q), .tx_ready(tx_ready), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .counts_per_rev_q(counts_per_rev_q),
    .count_direction_invert(count_direction_invert),
    .encoder_kind_field(encoder_kind_field));
  host_model host (
    .sys_clk(sys_clk), .rx_ready(rx_ready), .tx_data_q(tx_data_q),
    .tx_valid_q(tx_valid_q), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_ready(tx_ready));
  always #5 sys_clk = ~sys_clk;
  task automatic conclude();
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk_word(input string s, input logic [31:0] e,
                          input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk_word
  task automatic chk_byte(input string s, input logic [7:0] e,
                          input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk_byte
  function automatic logic [31:0] mdl(input logic [7:0] a);
    if (a == 8'h24)
      return r[7][15:0] != 16'h0 ? {16'h0, r[7][15:0]} : r[8];
    if (a[1:0] != 2'h0 || a > 8'h28)
      return 32'h0;
    return r[a[7:2]];
  endfunction : mdl
  function automatic logic [15:0] crc_of();
    logic [15:0] c;
    c = settings_pkg::CRC_INIT;
    foreach (exp_q[i])
    begin
      c = c ^ {8'h00, exp_q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ settings_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc_of
  task automatic put(input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      exp_q.push_back(v[8*i +: 8]);
  endtask : put
  task automatic zeros(input int n);
    repeat (n) exp_q.push_back(8'h00);
  endtask : zeros
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk_word("reg_rdata_q", mdl(a), reg_rdata_q);
    @(posedge sys_clk);
  endtask : rd
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    if (a == settings_pkg::ADDR_ENC_FLAGS)
      d = d & settings_pkg::ENC_FLAG_MASK;
    if (a < 8'h24 && a[1:0] == 2'h0)
      r[a[7:2]] = d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    rd(a);
  endtask : wr_rd
  // builds the expected answer, runs one exchange, compares
  task automatic frame(input logic [31:0] cmd);
    logic [15:0] c;
    int          n;
    exp_q.delete();
    put(cmd);
    case (cmd)
      settings_pkg::CMD_ENC_SETTINGS:
      begin
        for (int k = 0; k < 6; k++)
          put(r[k]);
        zeros(24);
      end
      settings_pkg::CMD_MOTOR_KIND:
      begin
        exp_q.push_back(r[6][7:0]);
        exp_q.push_back(r[6][15:8]);
        zeros(6);
      end
      settings_pkg::CMD_FEEDBACK:
      begin
        put(r[7]);
        put(r[8]);
        zeros(4);
      end
      default:
        exp_q.delete();
    endcase
    c = crc_of();
    if (exp_q.size() > 0)
      exp_q = {exp_q, c[7:0], c[15:8]};
    host.got.delete();
    host.send(cmd);
    n = 0;
    while (host.got.size() < exp_q.size() && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    repeat (20) @(posedge sys_clk);
    if (n == 3000)
    begin
      miscompares++;
      conclude();
    end
    chk_word("answer_length", 32'(exp_q.size()),
             32'(host.got.size()));
    foreach (exp_q[i])
      if (i < host.got.size())
        chk_byte("answer_byte", exp_q[i],
                 host.got[i]);
  endtask : frame
  initial
  begin
    foreach (r[i])
      r[i] = 32'h0;
    r[6] = settings_pkg::RST_KINDS;
    r[7] = settings_pkg::RST_FEEDBACK;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 0; a <= 48; a += 4)
      rd(a[7:0]);
    rd(8'h03);
    for (int a = 0; a <= 40; a += 4)
      wr_rd(a[7:0], host.rnd()
            & (a == 24 ? 32'hffff : 32'hffffffff));
    wr_rd(8'h40, host.rnd());
    host.slow = 1'b1;
    frame(settings_pkg::CMD_ENC_SETTINGS);
    for (int i = 0; i < 6; i++)
    begin
      host.slow = i[0];
      wr_rd(8'h18, {16'h0, 8'(1 + i % 3), 8'(i)});
      frame(settings_pkg::CMD_MOTOR_KIND);
    end
    for (int i = 0; i < 3; i++)
    begin
      host.slow = i[0];
      wr_rd(8'h20, host.rnd());
      // legacy count zero except once
      wr_rd(8'h1c, {FB_FLAG[8*i +: 8], FB_KIND[8*i +: 8],
                   i == 1 ? 16'(host.rnd()) : 16'h0});
      @(negedge sys_clk);
      chk_word("counts_per_rev_q", mdl(8'h24), counts_per_rev_q);
      chk_word("dir_invert", 32'(FB_FLAG[8*i]),
               32'(count_direction_invert));
      chk_word("enc_kind", 32'(FB_FLAG[8*i+6 +: 2]),
               32'(encoder_kind_field));
      @(posedge sys_clk);
      frame(settings_pkg::CMD_FEEDBACK);
    end
    frame(32'h12345678);
    chk_word("rx_ready", 32'h1, 32'(rx_ready));
    host.slow = 1'b1;
    frame(settings_pkg::CMD_ENC_SETTINGS);
    // status: 11 answers sent, 1 unknown command, idle
    r[10] = 32'h000b0100;
    rd(settings_pkg::ADDR_STATUS);
    conclude();
  end
endmodule : tb
